// ==== hw/ahp_host_port.v ====
// Purpose: parallel host port of a sigma-delta converter
// Assumes: pins are asynchronous to clk; samples arrive on clk
// Notes: strobes are seen two cycles late through the synchronisers
//
// How it works
// R1 - 16-bit three-state bus, steered by select pins
// R2 - reset falling edge clears logic, powers down
// R3 - held reset keeps converter idle, bus released
// R4 - restart falling edge clears the decimation filter
// R5 - select low, direction low: device drives bus
// R6 - select low, direction high: device takes word
// R7 - ready pulses low half a conversion period
// R8 - host supplies master clock; rate follows it
// R9 - valid flag waits twice filter plus computation
// R10 - host releases bus during device reads
`timescale 1ns/1ns
`default_nettype none
`include "ahp_map.vh"
module ahp_host_port #(
    parameter DATA_W = `AHP_DATA_W,
    parameter CONVERSION_CLOCK_DIV = `AHP_CONVERSION_CLOCK_DIV,
    parameter DECIM = `AHP_DECIM,
    parameter SETTLE_CYC = `AHP_SETTLE_CYC
) (
    // master clock, reset pin, clock enable
    input wire clk,
    input wire arst_n,
    input wire clk_en,
    // control pins from the host
    input wire sync_n,
    input wire cs_n,
    input wire rd_wr,
    // three-state data bus, split
    input wire [DATA_W-1:0] bus_in,
    output reg [DATA_W-1:0] bus_out,
    output reg bus_oe_n,
    // status pins
    output reg result_ready_n,
    output reg result_valid_flag,
    output reg powered_down,
    output reg conversion_clock,
    // samples from the modulator side
    input wire [DATA_W-1:0] sample_data,
    input wire sample_valid,
    output wire sample_ready,
    // words written by the host
    output reg [DATA_W-1:0] write_data,
    output reg write_strobe
);
    localparam PW = DATA_W + 3;
    localparam integer HALF_I = CONVERSION_CLOCK_DIV / 2 - 1;
    localparam integer DEC_I = DECIM - 1;
    localparam integer SETTLE_I = SETTLE_CYC;
    localparam [7:0] HALF_M1 = HALF_I[7:0];
    localparam [7:0] DEC_M1 = DEC_I[7:0];
    localparam [15:0] SETTLE = SETTLE_I[15:0];

    ////////////////////////////////////////////////////////////////////
    // reset release
    reg rst_meta;
    reg rst_n;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0; // R2
            rst_n <= 1'b0;
        end else if (clk_en) begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; only the second stage is read by logic
    wire [PW-1:0] pin_raw = {sync_n, cs_n, rd_wr, bus_in};
    reg [PW-1:0] pin_meta;
    reg [PW-1:0] pin_s;
    reg sync_d;
    reg cs_d;
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= {PW{1'b1}};
            pin_s <= {PW{1'b1}};
            sync_d <= 1'b1;
            cs_d <= 1'b1;
        end else if (clk_en) begin
            pin_meta <= pin_raw;
            pin_s <= pin_meta;
            sync_d <= pin_s[PW-1];
            cs_d <= pin_s[PW-2];
        end
    end
    wire sync_s = pin_s[PW-1];
    wire cs_s = pin_s[PW-2];
    wire rw_s = pin_s[PW-3];
    wire [DATA_W-1:0] din_s = pin_s[DATA_W-1:0];
    wire restart = sync_d & ~sync_s; // R4
    wire cs_rise = ~cs_d & cs_s;
    wire rd_act = ~cs_s & ~rw_s; // R5
    wire wr_act = ~cs_s & rw_s; // R6

    ////////////////////////////////////////////////////////////////////
    // conversion clock, derived from the master clock
    reg [7:0] conversion_clock_cnt;
    always @(posedge clk) begin
        if (!rst_n || (clk_en && powered_down)) begin
            conversion_clock_cnt <= 8'h00; // R3
            conversion_clock <= 1'b0;
        end else if (clk_en) begin
            if (conversion_clock_cnt == HALF_M1) begin
                conversion_clock_cnt <= 8'h00; // R8
                conversion_clock <= ~conversion_clock;
            end else begin
                conversion_clock_cnt <= conversion_clock_cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decimation: keeps every DECIM-th sample as a result
    reg [7:0] dec_cnt;
    wire buf_in_ready;
    wire dec_last = (dec_cnt == DEC_M1);
    // a stalled buffer stalls the source only on the sample it would take
    assign sample_ready = rst_n & ~powered_down & ~restart & (~dec_last | buf_in_ready);
    wire take = sample_valid & sample_ready;
    wire buf_push = take & dec_last;
    always @(posedge clk) begin
        if (!rst_n || (clk_en && powered_down)) begin
            dec_cnt <= 8'h00; // R3
        end else if (clk_en) begin
            if (restart) begin
                dec_cnt <= 8'h00; // R4
            end else if (take) begin
                dec_cnt <= dec_last ? 8'h00 : dec_cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // settling after restart or reset
    reg [15:0] settle_cnt;
    always @(posedge clk) begin
        if (!rst_n) begin
            settle_cnt <= SETTLE;
            result_valid_flag <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                settle_cnt <= SETTLE; // R9
                result_valid_flag <= 1'b0;
            end else if (!powered_down && settle_cnt != 16'h0000) begin
                settle_cnt <= settle_cnt - 16'h0001;
                if (settle_cnt == 16'h0001) begin
                    result_valid_flag <= 1'b1; // R9
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result buffer
    wire [DATA_W-1:0] head;
    wire head_valid;
    reg rd_open;
    reg rd_had;
    wire pop = cs_rise & rd_open & rd_had;
    ahp_buf2 #(
        .DATA_W(DATA_W)
    ) u_buf (
        .clk(clk),
        .clk_en(clk_en),
        .rst_n(rst_n),
        .in_data(sample_data),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .out_data(head),
        .out_valid(head_valid),
        .out_ready(pop)
    );

    ////////////////////////////////////////////////////////////////////
    // data-ready pulse, once per new head word
    reg announced;
    reg [7:0] rdy_cnt;
    wire rdy_start = head_valid & ~announced & ~pop & ~powered_down;
    always @(posedge clk) begin
        if (!rst_n) begin
            announced <= 1'b0;
            rdy_cnt <= 8'h00;
            result_ready_n <= 1'b1;
        end else if (clk_en) begin
            if (pop) begin
                announced <= 1'b0;
            end else if (rdy_start) begin
                announced <= 1'b1;
            end
            if (rdy_start) begin
                result_ready_n <= 1'b0; // R7
                rdy_cnt <= HALF_M1;
            end else if (rdy_cnt != 8'h00) begin
                rdy_cnt <= rdy_cnt - 8'h01;
            end else begin
                result_ready_n <= 1'b1; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus cycles; a read pops the word when the select rises
    reg wr_open;
    reg [DATA_W-1:0] wr_word;
    always @(posedge clk) begin
        if (!rst_n) begin
            bus_out <= {DATA_W{1'b0}};
            bus_oe_n <= 1'b1; // R3
            rd_open <= 1'b0;
            rd_had <= 1'b0;
            wr_open <= 1'b0;
            wr_word <= {DATA_W{1'b0}};
            write_data <= {DATA_W{1'b0}};
            write_strobe <= 1'b0;
            powered_down <= 1'b1; // R2
        end else if (clk_en) begin
            write_strobe <= 1'b0;
            // drive only while a read is selected, released otherwise
            bus_oe_n <= ~rd_act; // R1 R10
            if (rd_act && !rd_open) begin
                bus_out <= head_valid ? head : {DATA_W{1'b0}}; // R5
                rd_had <= head_valid;
            end
            if (cs_s) begin
                rd_open <= 1'b0;
                wr_open <= 1'b0;
            end else begin
                rd_open <= rd_open | rd_act;
                wr_open <= wr_open | wr_act;
            end
            if (wr_act) begin
                wr_word <= din_s;
            end
            if (cs_rise && wr_open) begin
                write_data <= wr_word; // R6
                write_strobe <= 1'b1;
                powered_down <= ~wr_word[`AHP_PWRUP_BIT];
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/ahp_map.vh ====
// Purpose: constants of the converter's parallel host port
// Assumes: master clock of 100 MHz (10 ns period)
// Notes: times in ns, cycle counts derived from them
`ifndef AHP_MAP_VH
`define AHP_MAP_VH

`define AHP_DATA_W 16
`define AHP_CLK_PERIOD_NS 10
// conversion clock = master clock / this ratio (even)
`define AHP_CONVERSION_CLOCK_DIV 4
// samples combined into one result by the decimation filter
`define AHP_DECIM 4
// settle after a filter restart: twice filter delay plus computation
`define AHP_FILTER_DELAY_NS 1200
`define AHP_COMP_DELAY_NS 325
`define AHP_SETTLE_NS (2 * `AHP_FILTER_DELAY_NS + `AHP_COMP_DELAY_NS)
`define AHP_SETTLE_CYC ((`AHP_SETTLE_NS + `AHP_CLK_PERIOD_NS - 1) / `AHP_CLK_PERIOD_NS)
// bit of a written word that powers the converter up
`define AHP_PWRUP_BIT 0
`define AHP_BUF_DEPTH 2

`endif

// ==== hw/ahp_buf2.v ====
// Purpose: two-entry result buffer with valid/ready on both sides
// Assumes: synchronous active-low reset, clock enable freezes state
// Notes: full and empty are exact; in_ready drops when both entries held
`timescale 1ns/1ns
`default_nettype none
module ahp_buf2 #(
    parameter DATA_W = 16
) (
    // clock and reset
    input wire clk,
    input wire clk_en,
    input wire rst_n,
    // filling side
    input wire [DATA_W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    // draining side
    output wire [DATA_W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [DATA_W-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    always @(posedge clk) begin
        if (clk_en && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/ahp_chk_sva.sv ====
// Purpose: port checker of the converter host port
// Assumes: pins held per the hand-over timing, settle count as bound
// Notes: bus latency through the synchronisers is three edges
`timescale 1ns/1ns
`default_nettype none
module ahp_chk #(
    parameter int SETTLE_CYC = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // host pins
    input wire logic sync_n,
    input wire logic cs_n,
    input wire logic rd_wr,
    // watched outputs
    input wire logic bus_oe_n,
    input wire logic [15:0] write_data,
    input wire logic write_strobe,
    input wire logic result_ready_n,
    input wire logic result_valid_flag,
    input wire logic powered_down,
    input wire logic conversion_clock,
    input wire logic sample_ready
);
    int low_cnt;
    default clocking cb @(posedge clk); endclocking
    // a frozen clock enable stretches every timing below, so checks pause with it
    default disable iff (!arst_n || !clk_en);
    ////////////////////////////////////////////////////////////////////////////////
    // cycles the valid flag has been low, to bound how soon it may rise
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) low_cnt <= 0;
        else low_cnt <= result_valid_flag ? 0 : low_cnt + 1;
    end
    chk_bus_release: assert property ((cs_n | rd_wr) [*5] |-> bus_oe_n)
        else $error("bus driven outside a read");
    chk_read_drive: assert property ((!cs_n & !rd_wr) [*4] |=> !bus_oe_n)
        else $error("bus not driven during a read");
    chk_strobe_once: assert property (write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    chk_write_power: assert property (write_strobe |=> powered_down == !write_data[0])
        else $error("power state does not follow written word");
    chk_ready_width: assert property ($fell(result_ready_n) |=> !result_ready_n ##1 result_ready_n)
        else $error("ready pulse not two cycles wide");
    // the conversion clock is a register, so it stops one edge after power-down
    chk_down_idle: assert property (powered_down |-> !sample_ready ##1 !conversion_clock)
        else $error("activity while powered down");
    chk_conv_rate: assert property (disable iff (!arst_n || !clk_en || powered_down)
        $rose(conversion_clock) |=> conversion_clock ##1 !conversion_clock ##1 !conversion_clock)
        else $error("conversion clock not master divided by four");
    chk_restart_clear: assert property ($fell(sync_n) |-> ##[1:4] !result_valid_flag)
        else $error("restart did not clear valid flag");
    chk_settle_wait: assert property ($rose(result_valid_flag) |-> low_cnt >= SETTLE_CYC - 1)
        else $error("valid flag rose before settling");
endmodule
bind ahp_host_port ahp_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .arst_n(arst_n),
    .clk_en(clk_en),
    .sync_n(sync_n), .cs_n(cs_n), .rd_wr(rd_wr), .bus_oe_n(bus_oe_n), .write_data(write_data),
    .write_strobe(write_strobe), .result_ready_n(result_ready_n),
    .result_valid_flag(result_valid_flag), .powered_down(powered_down),
    .conversion_clock(conversion_clock), .sample_ready(sample_ready));
`default_nettype wire

// ==== sim/ahp_host_model.sv ====
// Purpose: host controller on the far side of the data bus
// Assumes: hold counts of at least one cycle
// Notes: a released bus shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module ahp_host_model (
    input wire logic clk,
    input wire logic [15:0] bus_out,
    input wire logic bus_oe_n,
    output logic cs_n = 1'b1,
    output logic rd_wr = 1'b1,
    output logic [15:0] bus_in
);
    logic drv = 1'b0;
    logic [15:0] w = 16'h0000;
    logic [15:0] last = 16'h0000;
    // stale levels must never pass for data, so nobody driving means inverted
    always_comb bus_in = !bus_oe_n ? bus_out : drv ? w : ~last;
    always @(posedge clk) last <= bus_in;
    task automatic write_word(input logic [15:0] d, input int hold);
        @(posedge clk);
        #1 cs_n = 0;
        rd_wr = 1;
        drv = 1;
        w = d;
        repeat (hold) @(posedge clk);
        #1 cs_n = 1;
        repeat (4) @(posedge clk);
        #1 drv = 0;
    endtask
    task automatic read_word(input int hold, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1 cs_n = 0;
        rd_wr = 0;
        while (bus_oe_n !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        repeat (hold) @(posedge clk);
        #1 d = bus_in;
        cs_n = 1;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the converter host port
// Assumes: settle count shortened to 5 cycles
// Notes: select, direction and bus pins come from the partner model; sync_n is driven by the bench
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, arst_n = 0, sync_n = 1, sample_valid = 0, clk_en = 1;
    logic [15:0] sample_data = 16'h0000, rd, got_wd;
    wire logic cs_n, rd_wr, bus_oe_n, result_ready_n, result_valid_flag, powered_down;
    wire logic conversion_clock, sample_ready, write_strobe;
    wire logic [15:0] bus_in, bus_out, write_data;
    wire logic [6:0] status = {bus_oe_n, result_ready_n, result_valid_flag, powered_down,
        conversion_clock, write_strobe, sample_ready};
    int mismatches = 0, num_checks = 0, n_wr = 0, n_rdy = 0;
    always #5 clk = ~clk;
    ahp_host_port #(.SETTLE_CYC(5)) u_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .sync_n(sync_n), .cs_n(cs_n), .rd_wr(rd_wr), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe_n(bus_oe_n), .result_ready_n(result_ready_n),
        .result_valid_flag(result_valid_flag), .powered_down(powered_down),
        .conversion_clock(conversion_clock), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .write_data(write_data), .write_strobe(write_strobe));
    ahp_host_model u_host (.clk(clk), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
        .cs_n(cs_n), .rd_wr(rd_wr), .bus_in(bus_in));
    always @(posedge clk) begin
        if (write_strobe === 1'b1) begin
            got_wd <= write_data;
            n_wr <= n_wr + 1;
        end
    end
    always @(negedge result_ready_n) n_rdy++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic push(input logic [15:0] d);
        int n;
        n = 0;
        sample_data = d;
        sample_valid = 1;
        while (!sample_ready && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        arst_n = 0;
        repeat (12) @(posedge clk);
        #1 chk16(status, 7'h68);
        arst_n = 1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_write(input logic [15:0] d, input int hold);
        int k;
        k = n_wr;
        u_host.write_word(d, hold);
        repeat (3) @(posedge clk);
        #1 chk16(n_wr - k, 16'h0001);
        chk16(got_wd, d);
        chk16(powered_down, !d[0]);
    endtask
    // the twelfth sample is offered while both entries are held, so it must wait
    task automatic t_stream;
        int k;
        k = n_rdy;
        for (int i = 1; i <= 11; i++) push(16'hA000 + i[15:0]);
        sample_data = 16'hA00C;
        repeat (3) @(posedge clk);
        #1 chk16(sample_ready, 1'b0);
        u_host.read_word(2, rd);
        chk16(rd, 16'hA004);
        repeat (2) @(posedge clk);
        #1 sample_valid = 0;
        u_host.read_word(6, rd);
        chk16(rd, 16'hA008);
        u_host.read_word(1, rd);
        chk16(rd, 16'hA00C);
        u_host.read_word(1, rd);
        chk16(rd, 16'h0000);
        chk16(n_rdy - k, 16'h0003);
    endtask
    task automatic t_restart;
        int n;
        n = 0;
        chk16(result_valid_flag, 1'b1);
        sync_n = 0;
        repeat (4) @(posedge clk);
        #1 chk16(result_valid_flag, 1'b0);
        sync_n = 1;
        while (result_valid_flag !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        chk16(n >= 4 && n <= 6, 1'b1);
    endtask
    // while the enable is low nothing may move, not even the conversion clock
    task automatic t_freeze;
        logic [6:0] s;
        s = status;
        clk_en = 0;
        repeat (6) @(posedge clk);
        #1 chk16(status, s);
        clk_en = 1;
    endtask
    initial begin
        t_reset();
        t_write(16'h0001, 4);
        repeat (20) @(posedge clk);
        #1 t_stream();
        t_restart();
        t_freeze();
        t_reset();
        t_write(16'h5A01, 9);
        t_write(16'hFFFE, 4);
        report_and_stop();
    end
    initial begin
        #50000;
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
